// ===== design/motor_out_pkg.sv
// Package with register map, field layout, reset values and timing for the motor output stage.
package motor_out_pkg;
  localparam logic [3:0] ADDR_CMP_ZERO_LOW  = 4'h0;
  localparam logic [3:0] ADDR_CMP_ZERO_HIGH = 4'h1;
  localparam logic [3:0] ADDR_DEADTIME      = 4'h2;
  localparam logic [3:0] ADDR_POLARITY      = 4'h3;
  localparam logic [3:0] ADDR_PHASE_STATE   = 4'h4;
  localparam logic [3:0] ADDR_CONTROL_A     = 4'h5;
  localparam logic [3:0] ADDR_CONTROL_B     = 4'h6;
  localparam logic [3:0] ADDR_REFERENCE     = 4'h7;
  localparam logic [3:0] ADDR_CMP_ACTIVE_LO = 4'h8;
  localparam logic [3:0] ADDR_CMP_ACTIVE_HI = 4'h9;

  localparam logic [7:0] RESET_CMP_ZERO_LOW  = 8'hFF;
  localparam logic [3:0] RESET_CMP_ZERO_HIGH = 4'hF;
  localparam logic [7:0] RESET_DEADTIME      = 8'hFF;
  localparam logic [7:0] RESET_POLARITY      = 8'h3F;
  localparam logic [7:0] RESET_ZERO          = 8'h00;

  localparam int BIT_CHANNEL_COUNT = 7;
  localparam int BIT_DEADTIME_EN   = 6;
  localparam int BIT_ZC_EDGE       = 7;
  localparam int BIT_BEMF_READ     = 6;
  localparam int BIT_CLOCK_EN      = 0;
  localparam int BIT_MAIN_OUT_EN   = 1;
  localparam int BIT_DIRECT_ACCESS = 2;
  localparam int BIT_OUT_SEL_ZERO  = 0;
  localparam int BIT_OUT_SEL_TWO   = 1;
  localparam int BIT_CHOP_EN_LO    = 3;
  localparam int BIT_CHOP_EN_HI    = 4;

  localparam int DEADTIME_STEP_NS = 125;
  localparam int CLK_PERIOD_NS    = 8;
  localparam int DEADTIME_STEP_CYCLES = (DEADTIME_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHOP_BASE_KHZ    = 100;
  localparam int CLK_KHZ          = 125000;
  localparam int CHOP_HALF_CYCLES = CLK_KHZ / (2 * CHOP_BASE_KHZ);
endpackage

// ===== design/deadtime_pair.sv
// One complementary channel pair with dead time insertion.
`timescale 1ns/1ps
`default_nettype none
module deadtime_pair
  import motor_out_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
)(
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   pwm_in,
  input  wire logic                   insert_deadtime,
  input  wire logic [COUNT_WIDTH-1:0] delay_cycles,
  output logic                        high_on,
  output logic                        low_on
);
  logic                   last_pwm;
  logic [COUNT_WIDTH-1:0] wait_count;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      last_pwm   <= 1'b0;
      wait_count <= '0;
      high_on    <= 1'b0;
      low_on     <= 1'b0;
    end
    else
    begin
      last_pwm <= pwm_in;
      if (!insert_deadtime)
      begin
        high_on    <= pwm_in;
        low_on     <= !pwm_in;
        wait_count <= '0;
      end
      else if (pwm_in != last_pwm)
      begin
        high_on    <= 1'b0;
        low_on     <= 1'b0;
        wait_count <= delay_cycles;
      end
      else if (wait_count != '0)
        wait_count <= wait_count - 1'b1;
      else
      begin
        high_on <= pwm_in;
        low_on  <= !pwm_in;
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/write_once_lock.sv
// Lock flag that closes on the first write access and opens only on reset.
`timescale 1ns/1ps
`default_nettype none
module write_once_lock (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic write_access,
  output logic      locked
);
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      locked <= 1'b0;
    else if (write_access)
      locked <= 1'b1;
  end
endmodule
`default_nettype wire

// ===== design/motor_output_deadtime_polarity.sv
// Output stage: compare-zero preload, preload transfer, dead time, polarity and write-once locks.
// Overview of operation
// - Compare-zero low byte, RW, resets all ones.
// - Compare-zero high bits 3:0, reset 0Fh.
// - Both compare halves written before update applies.
// - Buffered fields apply on commutation or phase write.
// - Phase and control B writes go to preload, reads return active.
// - Phase and control B preloads transfer together on the trigger; compare zero on update.
// - A write to a register locks its own write-once bits until reset.
// - Dead time resets FFh; bit 7 picks channels.
// - Bit 6 enables dead time and complements.
// - Enable write-once only while selector is set.
// - Complementary output table per selector and enable.
// - Outputs act only with clock and main enable.
// - Single channel direct no dead time: plain.
// - Single channel direct with dead time: paired.
// - Optional chopper overlays the PWM output.
// - Six-bit dead time field sets duration, write-once.
// - Polarity resets 3Fh; bit 7 edge polarity.
// - Bit 6 selects back-EMF read channel.
// - Polarity and output-on give pin level.
`timescale 1ns/1ps
`default_nettype none
module motor_output_deadtime_polarity
  import motor_out_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
)(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       commutation_event,
  input  wire logic       update_event,
  input  wire logic [2:0] pwm_phase,
  output logic      [5:0] channel_output_pin,
  output logic            zc_demag_edge_polarity,
  output logic            bemf_read_channel,
  output logic            output_select_two,
  output logic     [11:0] compare_zero_value
);
  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] cmp_zero_low_byte;
  logic [3:0] cmp_zero_high_bits;
  logic       low_written;
  logic       high_written;
  logic [7:0] deadtime_setup;
  logic [7:0] output_polarity;
  logic [7:0] control_register_a;
  logic [7:0] control_register_b;
  logic [7:0] reference_register;
  logic [5:0] phase_preload;
  logic [5:0] channel_output_on;
  logic [7:0] control_b_active;
  logic       deadtime_locked;
  logic       polarity_locked;

  wire logic  wr_low        = reg_write && reg_addr == ADDR_CMP_ZERO_LOW;
  wire logic  wr_high       = reg_write && reg_addr == ADDR_CMP_ZERO_HIGH;
  wire logic  wr_deadtime   = reg_write && reg_addr == ADDR_DEADTIME;
  wire logic  wr_polarity   = reg_write && reg_addr == ADDR_POLARITY;
  wire logic  wr_phase      = reg_write && reg_addr == ADDR_PHASE_STATE;
  wire logic  direct_access = control_register_a[BIT_DIRECT_ACCESS];
  // Direct access loads on a phase write, normal mode on a commutation event.
  wire logic  load_active   = direct_access ? wr_phase : commutation_event;

  // One lock flag for each register holding write-once bits.
  write_once_lock u_lock_deadtime (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .write_access (wr_deadtime),
    .locked       (deadtime_locked)
  );

  write_once_lock u_lock_polarity (
    .clk_sys      (clk_sys),
    .reset_n      (reset_n),
    .write_access (wr_polarity),
    .locked       (polarity_locked)
  );

  // ****************************************************************
  // Compare-zero preload and update
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      cmp_zero_low_byte  <= RESET_CMP_ZERO_LOW;
      cmp_zero_high_bits <= RESET_CMP_ZERO_HIGH;
      low_written        <= 1'b0;
      high_written       <= 1'b0;
      compare_zero_value <= {RESET_CMP_ZERO_HIGH, RESET_CMP_ZERO_LOW};
    end
    else
    begin
      if (wr_low)
        cmp_zero_low_byte <= reg_wdata;
      if (wr_high)
        cmp_zero_high_bits <= reg_wdata[3:0];
      // A write in the update cycle starts a fresh pair.
      if (update_event && low_written && high_written)
      begin
        compare_zero_value <= {cmp_zero_high_bits, cmp_zero_low_byte};
        low_written        <= wr_low;
        high_written       <= wr_high;
      end
      else
      begin
        low_written  <= low_written || wr_low;
        high_written <= high_written || wr_high;
      end
    end
  end

  // ****************************************************************
  // Write-once configuration registers
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      deadtime_setup <= RESET_DEADTIME;
    else if (wr_deadtime)
    begin
      deadtime_setup[BIT_CHANNEL_COUNT] <= reg_wdata[BIT_CHANNEL_COUNT];
      // The enable is frozen once locked while three channels are selected.
      if (!(deadtime_locked && deadtime_setup[BIT_CHANNEL_COUNT]))
        deadtime_setup[BIT_DEADTIME_EN] <= reg_wdata[BIT_DEADTIME_EN];
      if (!deadtime_locked)
        deadtime_setup[5:0] <= reg_wdata[5:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      output_polarity <= RESET_POLARITY;
    else if (wr_polarity)
    begin
      output_polarity[BIT_ZC_EDGE]   <= reg_wdata[BIT_ZC_EDGE];
      output_polarity[BIT_BEMF_READ] <= reg_wdata[BIT_BEMF_READ];
      if (!polarity_locked)
        output_polarity[5:0] <= reg_wdata[5:0];
    end
  end

  // ****************************************************************
  // Control registers and commutation preloads
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      control_register_a <= RESET_ZERO;
      control_register_b <= RESET_ZERO;
      reference_register <= RESET_ZERO;
      phase_preload      <= '0;
    end
    else
    begin
      if (reg_write && reg_addr == ADDR_CONTROL_A)
        control_register_a <= reg_wdata;
      if (reg_write && reg_addr == ADDR_CONTROL_B)
        control_register_b <= reg_wdata;
      if (reg_write && reg_addr == ADDR_REFERENCE)
        reference_register <= reg_wdata;
      if (wr_phase)
        phase_preload <= reg_wdata[5:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      channel_output_on <= '0;
      control_b_active  <= RESET_ZERO;
    end
    else if (load_active)
    begin
      // In direct access the freshly written phase value moves straight through.
      channel_output_on <= wr_phase ? reg_wdata[5:0] : phase_preload;
      control_b_active  <= control_register_b;
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      reg_rdata <= RESET_ZERO;
    else if (reg_read)
    begin
      case (reg_addr)
        ADDR_CMP_ZERO_LOW:  reg_rdata <= cmp_zero_low_byte;
        ADDR_CMP_ZERO_HIGH: reg_rdata <= {4'h0, cmp_zero_high_bits};
        ADDR_DEADTIME:      reg_rdata <= deadtime_setup;
        ADDR_POLARITY:      reg_rdata <= output_polarity;
        ADDR_PHASE_STATE:   reg_rdata <= {2'b00, channel_output_on};
        ADDR_CONTROL_A:     reg_rdata <= control_register_a;
        ADDR_CONTROL_B:     reg_rdata <= control_b_active;
        ADDR_REFERENCE:     reg_rdata <= reference_register;
        ADDR_CMP_ACTIVE_LO: reg_rdata <= compare_zero_value[7:0];
        ADDR_CMP_ACTIVE_HI: reg_rdata <= {4'h0, compare_zero_value[11:8]};
        default:            reg_rdata <= RESET_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // Chopper
  // ****************************************************************
  logic      [COUNT_WIDTH-1:0] chop_count;
  logic                        chop_wave;
  wire logic [COUNT_WIDTH-1:0] chop_limit =
    COUNT_WIDTH'(CHOP_HALF_CYCLES >> reference_register[2:0]);
  wire logic                   chop_lo_en = reference_register[BIT_CHOP_EN_LO];
  wire logic                   chop_hi_en = reference_register[BIT_CHOP_EN_HI];

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      chop_count <= '0;
      chop_wave  <= 1'b0;
    end
    else if (chop_count >= chop_limit)
    begin
      chop_count <= '0;
      chop_wave  <= !chop_wave;
    end
    else
      chop_count <= chop_count + 1'b1;
  end

  // ****************************************************************
  // Dead time and channel output
  // ****************************************************************
  logic [2:0]             pair_pwm;
  logic [2:0]             pair_high;
  logic [2:0]             pair_low;
  logic [5:0]             drive;
  logic [5:0]             next_pin;
  wire logic              three_channel = deadtime_setup[BIT_CHANNEL_COUNT];
  wire logic              insert_dt     = deadtime_setup[BIT_DEADTIME_EN];
  wire logic [COUNT_WIDTH-1:0] dead_cycles =
    COUNT_WIDTH'((deadtime_setup[5:0] + 7'd1) * DEADTIME_STEP_CYCLES);
  // Selector 1 with enable 0 still complements, with zero dead time.
  wire logic              complementary = insert_dt || three_channel;
  wire logic              outputs_live  = control_register_a[BIT_CLOCK_EN]
                                       && control_register_a[BIT_MAIN_OUT_EN];
  // Single channel routes only phase U; output select zero picks the PWM'd side.
  assign pair_pwm = three_channel ? pwm_phase : {3{pwm_phase[0]}};

  for (genvar g = 0; g < 3; g = g + 1)
  begin : g_pair
    deadtime_pair #(.COUNT_WIDTH(COUNT_WIDTH)) u_pair (
      .clk_sys         (clk_sys),
      .reset_n         (reset_n),
      .pwm_in          (pair_pwm[g]),
      .insert_deadtime (insert_dt),
      .delay_cycles    (dead_cycles),
      .high_on         (pair_high[g]),
      .low_on          (pair_low[g])
    );
  end

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (complementary)
      begin
        drive[2*i]   = channel_output_on[2*i]
                    && (control_b_active[BIT_OUT_SEL_ZERO] ? pair_low[i] : pair_high[i]);
        drive[2*i+1] = channel_output_on[2*i+1]
                    && (control_b_active[BIT_OUT_SEL_ZERO] ? pair_high[i] : pair_low[i]);
      end
      else
      begin
        // Plain PWM or a static level, no complement.
        drive[2*i]   = channel_output_on[2*i] && (pair_pwm[i] || !output_select_two);
        drive[2*i+1] = channel_output_on[2*i+1] && (pair_pwm[i] || !output_select_two);
      end
      if (chop_wave == 1'b0)
      begin
        if (chop_lo_en)
          drive[2*i+1] = 1'b0;
        if (chop_hi_en)
          drive[2*i] = 1'b0;
      end
    end
    if (!outputs_live)
      drive = '0;
    next_pin = ~(drive ^ output_polarity[5:0]);
  end

  assign output_select_two      = control_b_active[BIT_OUT_SEL_TWO];
  assign zc_demag_edge_polarity = output_polarity[BIT_ZC_EDGE];
  assign bemf_read_channel      = output_polarity[BIT_BEMF_READ];

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      channel_output_pin <= ~RESET_POLARITY[5:0];
    else
      channel_output_pin <= next_pin;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_locked_polarity;
    @(posedge clk_sys) disable iff (!reset_n)
      (wr_polarity && polarity_locked) |=> output_polarity[5:0] == $past(output_polarity[5:0]);
  endproperty
  a_locked_polarity: assert property (p_locked_polarity) else $error("polarity moved");
  property p_locked_deadtime;
    @(posedge clk_sys) disable iff (!reset_n)
      (wr_deadtime && deadtime_locked) |=> deadtime_setup[5:0] == $past(deadtime_setup[5:0]);
  endproperty
  a_locked_deadtime: assert property (p_locked_deadtime) else $error("dead time moved");
  property p_lock_sets;
    @(posedge clk_sys) disable iff (!reset_n)
      wr_deadtime |=> deadtime_locked;
  endproperty
  a_lock_sets: assert property (p_lock_sets) else $error("lock not set by write");
  property p_enable_frozen;
    @(posedge clk_sys) disable iff (!reset_n)
      (wr_deadtime && deadtime_locked && three_channel) |=> insert_dt == $past(insert_dt);
  endproperty
  a_enable_frozen: assert property (p_enable_frozen) else $error("frozen enable moved");
  property p_read_active;
    @(posedge clk_sys) disable iff (!reset_n)
      (reg_read && reg_addr == ADDR_PHASE_STATE)
        |=> reg_rdata == {2'b00, $past(channel_output_on)};
  endproperty
  a_read_active: assert property (p_read_active) else $error("phase read not active");
  property p_transfer;
    @(posedge clk_sys) disable iff (!reset_n)
      (load_active && !wr_phase) |=> channel_output_on == $past(phase_preload);
  endproperty
  a_transfer: assert property (p_transfer) else $error("preload not transferred");
  property p_off_level;
    @(posedge clk_sys) disable iff (!reset_n)
      !outputs_live |=> channel_output_pin == ~$past(output_polarity[5:0]);
  endproperty
  a_off_level: assert property (p_off_level) else $error("outputs not off");
  property p_pair_rule;
    @(posedge clk_sys) disable iff (!reset_n)
      (update_event && !(low_written && high_written))
        |=> compare_zero_value == $past(compare_zero_value);
  endproperty
  a_pair_rule: assert property (p_pair_rule) else $error("compare updated without pair");
endmodule
`default_nettype wire

// ===== testbench/power_stage_model.sv
// Model of the inverter legs that the six channel pins drive.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [5:0]  channel_output_pin,
  input  wire logic [5:0]  active_high,
  input  wire logic        arm,
  output logic             shoot_through,
  output logic      [15:0] last_gap
);
  logic [5:0]  switch_on;
  logic [15:0] gap_count;

  // A switch conducts while its pin sits at the channel's active level.
  assign switch_on = ~(channel_output_pin ^ active_high);

  // Both switches of one leg on at once would short the supply rail.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || !arm)
      shoot_through <= 1'b0;
    else if (|(switch_on[4:0] & switch_on[5:1] & 5'h15))
      shoot_through <= 1'b1;
  end

  // The last run of cycles with both switches of the first leg off.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || !arm)
    begin
      gap_count <= 16'h0000;
      last_gap <= 16'h0000;
    end
    else if (!switch_on[0] && !switch_on[1])
      gap_count <= gap_count + 16'h0001;
    else
    begin
      if (gap_count != 16'h0000)
        last_gap <= gap_count;
      gap_count <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking testbench for the motor output stage.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import motor_out_pkg::*;
  logic        clk_sys, reset_n, reg_write, reg_read, commutation_event, update_event, arm;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [2:0]  pwm_phase;
  logic [5:0]  channel_output_pin, active_high;
  logic        zc_demag_edge_polarity, bemf_read_channel, output_select_two, shoot_through;
  logic [11:0] compare_zero_value;
  logic [15:0] last_gap;
  int          n_errors, n_compared;

  motor_output_deadtime_polarity i_motor_output_deadtime_polarity (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .commutation_event(commutation_event), .update_event(update_event),
    .pwm_phase(pwm_phase), .channel_output_pin(channel_output_pin),
    .zc_demag_edge_polarity(zc_demag_edge_polarity), .bemf_read_channel(bemf_read_channel),
    .output_select_two(output_select_two), .compare_zero_value(compare_zero_value));

  power_stage_model i_power_stage_model (
    .clk_sys(clk_sys), .reset_n(reset_n), .channel_output_pin(channel_output_pin),
    .active_high(active_high), .arm(arm), .shoot_through(shoot_through),
    .last_gap(last_gap));

  // ****************
  // Bus and checks
  // ****************
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string w);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    chk(w, {4'h0, reg_rdata}, {4'h0, e});
  endtask

  task automatic pulse(input logic upd);
    @(posedge clk_sys);
    update_event <= upd;
    commutation_event <= !upd;
    @(posedge clk_sys);
    update_event <= 1'b0;
    commutation_event <= 1'b0;
    idle(2);
  endtask

  // Drives one high pulse on the U phase while the leg model watches.
  task automatic swing;
    @(posedge clk_sys);
    pwm_phase <= 3'b000;
    repeat (100) @(posedge clk_sys);
    arm <= 1'b1;
    pwm_phase <= 3'b001;
    repeat (100) @(posedge clk_sys);
    pwm_phase <= 3'b000;
    idle(100);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    rdchk(ADDR_CMP_ZERO_LOW, 8'hFF, "cmp_low");
    rdchk(ADDR_CMP_ZERO_HIGH, 8'h0F, "cmp_high");
    rdchk(ADDR_DEADTIME, 8'hFF, "deadtime");
    rdchk(ADDR_POLARITY, 8'h3F, "polarity");
    rdchk(4'hA, 8'h00, "unmapped");
    chk("cmp_value", compare_zero_value, 12'hFFF);
    chk("pins", 12'(channel_output_pin), 12'h000);
    $display("test reset done");
  endtask

  task automatic t_polarity;
    wr(ADDR_POLARITY, 8'h95);
    rdchk(ADDR_POLARITY, 8'h95, "pol_first");
    wr(ADDR_POLARITY, 8'h6A);
    rdchk(ADDR_POLARITY, 8'h55, "pol_locked");
    chk("zc_edge", 12'(zc_demag_edge_polarity), 12'h000);
    chk("bemf_chan", 12'(bemf_read_channel), 12'h001);
    active_high = 6'h15;
    idle(3);
    chk("pins_off", 12'(channel_output_pin), 12'h02A);
    $display("test polarity done");
  endtask

  task automatic t_dt_lock;
    wr(ADDR_DEADTIME, 8'hC1);
    rdchk(ADDR_DEADTIME, 8'hC1, "dt_first");
    wr(ADDR_DEADTIME, 8'h00);
    rdchk(ADDR_DEADTIME, 8'h41, "dt_en_held");
    wr(ADDR_DEADTIME, 8'h00);
    rdchk(ADDR_DEADTIME, 8'h01, "dt_cleared");
    $display("test deadtime lock done");
  endtask

  task automatic t_compare;
    wr(ADDR_CMP_ZERO_LOW, 8'h34);
    pulse(1'b1);
    chk("cmp_half", compare_zero_value, 12'hFFF);
    wr(ADDR_CMP_ZERO_HIGH, 8'hF2);
    rdchk(ADDR_CMP_ACTIVE_LO, 8'hFF, "cmp_act_old");
    pulse(1'b1);
    chk("cmp_pair", compare_zero_value, 12'h234);
    rdchk(ADDR_CMP_ACTIVE_HI, 8'h02, "cmp_act_hi");
    rdchk(ADDR_CMP_ACTIVE_LO, 8'h34, "cmp_act_lo");
    $display("test compare done");
  endtask

  task automatic t_transfer;
    int n_low;
    n_low = 0;
    wr(ADDR_CONTROL_A, 8'h03);
    wr(ADDR_CONTROL_B, 8'h02);
    wr(ADDR_PHASE_STATE, 8'h0F);
    rdchk(ADDR_PHASE_STATE, 8'h00, "phase_old");
    chk("sel_two_old", 12'(output_select_two), 12'h000);
    pulse(1'b0);
    rdchk(ADDR_PHASE_STATE, 8'h0F, "phase_new");
    chk("sel_two_new", 12'(output_select_two), 12'h001);
    wr(ADDR_CONTROL_A, 8'h07);
    wr(ADDR_CONTROL_B, 8'h00);
    wr(ADDR_PHASE_STATE, 8'h0F);
    idle(4);
    chk("sel_two_direct", 12'(output_select_two), 12'h000);
    chk("pins_static", 12'(channel_output_pin), 12'h025);
    wr(ADDR_REFERENCE, 8'h17);
    repeat (10)
    begin
      @(posedge clk_sys);
      #1;
      if (channel_output_pin == 6'h20)
        n_low++;
    end
    chk("chop_half", 12'(n_low), 12'((CHOP_HALF_CYCLES >> 7) + 1));
    wr(ADDR_REFERENCE, 8'h00);
    wr(ADDR_CONTROL_A, 8'h05);
    idle(4);
    chk("pins_no_moe", 12'(channel_output_pin), 12'h02A);
    $display("test transfer done");
  endtask

  task automatic t_gap;
    wr(ADDR_DEADTIME, 8'h41);
    rdchk(ADDR_DEADTIME, 8'h41, "dt_en_free");
    wr(ADDR_CONTROL_A, 8'h07);
    wr(ADDR_PHASE_STATE, 8'h3F);
    swing();
    chk("gap_len", 12'(last_gap >= 16'h001F && last_gap <= 16'h0021), 12'h001);
    chk("no_short", 12'(shoot_through), 12'h000);
    arm <= 1'b0;
    wr(ADDR_DEADTIME, 8'h80);
    rdchk(ADDR_DEADTIME, 8'h81, "dt_three");
    swing();
    chk("gap_zero", 12'(last_gap), 12'h000);
    chk("no_short2", 12'(shoot_through), 12'h000);
    arm <= 1'b0;
    $display("test deadtime gap done");
  endtask

  task automatic t_relock;
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    wr(ADDR_POLARITY, 8'h2A);
    rdchk(ADDR_POLARITY, 8'h2A, "pol_unlocked");
    $display("test relock done");
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    complete_run();
  end

  initial
  begin
    reset_n = 1'b0;
    {reg_write, reg_read, commutation_event, update_event, arm} = 5'h00;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    pwm_phase = 3'b000;
    active_high = 6'h3F;
    n_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_polarity();
    t_dt_lock();
    t_compare();
    t_transfer();
    t_gap();
    t_relock();
    complete_run();
  end
endmodule
`default_nettype wire
